// >>> prefetch_queue_bus_control.sv
// Purpose: Bus interface unit with opcode prefetch queue and queue status reporting
// Assumes: Execution unit holds its data request until done; even jump targets
// Notes: Pin inputs pass two flip-flops; read data is taken from the synchroniser
`timescale 1ns/1ns
// Function
// - Queue status pins show the queue activity of the previous clock.
// - The queue status pair reports each byte the execution unit takes from the queue, except in a jump clock, which reports flush.
// - The three active-low status pins encode the type of the bus cycle in progress.
// - Opcodes reach the execution unit only via the queue; data cycles run only on request.
// - The execution unit stalls while the byte it needs is not yet queued.
// - A data request met at the start of a fetch abandons it, leaves idle clocks, then runs.
// - Serving a data request lengthens the instruction by at most two clocks when the fetch under way has no wait states.
// - A request arriving where it slots in runs next with no idle states.
// - Five or six queued bytes mean full, and the bus then idles.
// - A fetch starts only when the queue has room for a whole word.
// - A jump flushes the queue; a fetch already under way runs out unused, then fetching restarts from the target.
// - Each not-ready clock adds one wait state between the third and fourth states.
// - A bus cycle has four states, address and latch strobe in the first, data after.
module prefetch_queue_bus_control
  import pfq_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Execution unit: instruction bytes
  input wire logic eu_take,
  input wire logic eu_first,
  output logic [BYTE_W-1:0] eu_byte,
  output logic eu_byte_valid,
  // Execution unit: jump
  input wire logic eu_jump,
  input wire logic [ADDR_W-1:0] eu_jump_addr,
  // Execution unit: data requests
  input wire logic eu_req,
  input wire logic eu_req_write,
  input wire logic [ADDR_W-1:0] eu_req_addr,
  input wire logic [DATA_W-1:0] eu_req_wdata,
  output logic eu_done,
  output logic [DATA_W-1:0] eu_rdata,
  // Bus pins
  output logic [DATA_W-1:0] ad_out,
  input wire logic [DATA_W-1:0] ad_in,
  output logic ad_oe_n,
  output logic [ADDR_W-DATA_W-1:0] addr_hi,
  output logic ale,
  input wire logic ready,
  output logic bus_cycle_type_bit_2_n,
  output logic bus_cycle_type_bit_1_n,
  output logic bus_cycle_type_bit_0_n,
  // Queue status pins
  output logic queue_state_bit_low,
  output logic queue_state_bit_high
);

  tstate_e ts_q;
  tstate_e ts_d;
  cycle_kind_e kind_q;
  cycle_kind_e kind_d;
  logic [1:0] ready_sync_q;
  logic [DATA_W-1:0] ad_s1_q;
  logic [DATA_W-1:0] ad_s2_q;
  logic [ADDR_W-1:0] fetch_addr_q;
  logic [ADDR_W-1:0] cyc_addr_q;
  logic [DATA_W-1:0] cyc_wdata_q;
  logic stale_q;
  logic data_run_q;
  logic [1:0] idle_cnt_q;
  logic [DATA_W-1:0] stage_q;
  logic [1:0] stage_cnt_q;
  logic [CNT_W-1:0] q_count;
  logic [CNT_W:0] q_level;
  logic inflight;
  logic [CNT_W:0] inflight_bytes;
  logic q_in_valid;
  logic q_in_ready;
  logic [BYTE_W-1:0] q_in_data;
  logic pending;
  logic can_start;
  logic room;
  logic start_data;
  logic start_fetch;
  logic abort;
  logic cyc_end;
  logic [2:0] type_d;
  logic [1:0] qs_d;

  // Pin synchronisers: ready and the address/data inputs
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      ready_sync_q <= 2'h0;
      ad_s1_q <= '0;
      ad_s2_q <= '0;
    end else begin
      ready_sync_q <= {ready_sync_q[0], ready};
      ad_s1_q <= ad_in;
      ad_s2_q <= ad_s1_q;
    end
  end

  pfq_byte_fifo #(
    .WIDTH(BYTE_W),
    .DEPTH(QUEUE_DEPTH)
  ) u_queue (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .clear(eu_jump),
    .in_valid(q_in_valid),
    .in_ready(q_in_ready),
    .in_data(q_in_data),
    .out_valid(eu_byte_valid),
    .out_ready(eu_take),
    .out_data(eu_byte),
    .count(q_count)
  );

  pfq_tstate_seq u_seq (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .start(start_data || start_fetch),
    .abort(abort),
    .ready_sync(ready_sync_q[1]),
    .state_q(ts_q),
    .state_d(ts_d)
  );

  // Fetched word drains into the queue low byte first
  assign q_in_valid = (stage_cnt_q != STAGE_EMPTY) && !eu_jump;
  assign q_in_data = (stage_cnt_q == STAGE_TWO) ? stage_q[BYTE_W-1:0] : stage_q[DATA_W-1:BYTE_W];
  // A live fetch word counts as queued, so back-to-back fetches never pass capacity
  assign inflight = (ts_q != T_IDLE) && (kind_q == K_FETCH) && !stale_q;
  assign inflight_bytes = inflight ? (CNT_W+1)'(WORD_BYTES) : '0;
  assign q_level = {1'b0, q_count} + {{(CNT_W-1){1'b0}}, stage_cnt_q} + inflight_bytes;

  // Arbitration between a data request and the next opcode fetch
  always_comb begin
    pending = eu_req && !data_run_q && !eu_done; // Held request is old while done shows
    can_start = ((ts_q == T_IDLE) && (idle_cnt_q == 2'h0)) || (ts_q == T_FOUR);
    cyc_end = (ts_q == T_FOUR);
    room = (q_level <= (CNT_W+1)'(QUEUE_ROOM_LIMIT));
    start_data = can_start && pending;
    start_fetch = can_start && !pending && room && !eu_jump;
    abort = (ts_q == T_ONE) && (kind_q == K_FETCH) && pending;
    kind_d = kind_q;
    if (start_data) begin
      kind_d = eu_req_write ? K_WRITE : K_READ;
    end else if (start_fetch) begin
      kind_d = K_FETCH;
    end
  end

  // Cycle kind, address and write data captured at the start
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      kind_q <= K_FETCH;
      cyc_addr_q <= '0;
      cyc_wdata_q <= '0;
    end else begin
      kind_q <= kind_d;
      if (start_data) begin
        cyc_addr_q <= eu_req_addr;
        cyc_wdata_q <= eu_req_wdata;
      end else if (start_fetch) begin
        cyc_addr_q <= fetch_addr_q;
      end
    end
  end

  // Idle clocks after an abandoned fetch
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      idle_cnt_q <= 2'h0;
    end else if (abort) begin
      idle_cnt_q <= ABORT_IDLE - 2'h1;
    end else if ((ts_q == T_IDLE) && (idle_cnt_q != 2'h0)) begin
      idle_cnt_q <= idle_cnt_q - 2'h1;
    end
  end

  // Fetch pointer and overfetch marking
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      fetch_addr_q <= '0;
      stale_q <= 1'b0;
    end else begin
      if (eu_jump) begin
        fetch_addr_q <= eu_jump_addr & ADDR_EVEN;
        stale_q <= (ts_q != T_IDLE) && (kind_q == K_FETCH) && !cyc_end;
      end else begin
        if (abort) begin
          fetch_addr_q <= cyc_addr_q;
        end else if (start_fetch) begin
          fetch_addr_q <= fetch_addr_q + ADDR_STEP;
        end
        if (cyc_end) begin
          stale_q <= 1'b0;
        end
      end
    end
  end

  // Staging of a completed fetch word
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      stage_q <= '0;
      stage_cnt_q <= STAGE_EMPTY;
    end else if (eu_jump) begin
      stage_cnt_q <= STAGE_EMPTY;
    end else if (cyc_end && (kind_q == K_FETCH) && !stale_q) begin
      stage_q <= ad_s2_q;
      stage_cnt_q <= STAGE_TWO;
    end else if (q_in_valid && q_in_ready) begin
      stage_cnt_q <= stage_cnt_q - 2'h1;
    end
  end

  // Data request completion towards the execution unit
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      data_run_q <= 1'b0;
      eu_done <= 1'b0;
      eu_rdata <= '0;
    end else begin
      eu_done <= cyc_end && data_run_q;
      if (start_data) begin
        data_run_q <= 1'b1;
      end else if (cyc_end) begin
        data_run_q <= 1'b0;
      end
      if (cyc_end && (kind_q == K_READ)) begin
        eu_rdata <= ad_s2_q;
      end
    end
  end

  always_comb begin
    type_d = BUS_PASSIVE;
    if ((ts_d != T_IDLE) && (ts_d != T_FOUR)) begin
      case (kind_d)
        K_FETCH: type_d = BUS_FETCH;
        K_READ: type_d = BUS_READ;
        K_WRITE: type_d = BUS_WRITE;
        default: type_d = BUS_PASSIVE;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      ad_out <= '0;
      ad_oe_n <= 1'b1;
      addr_hi <= '0;
      ale <= 1'b0;
      bus_cycle_type_bit_2_n <= 1'b1;
      bus_cycle_type_bit_1_n <= 1'b1;
      bus_cycle_type_bit_0_n <= 1'b1;
    end else begin
      ale <= (ts_d == T_ONE);
      bus_cycle_type_bit_2_n <= type_d[2];
      bus_cycle_type_bit_1_n <= type_d[1];
      bus_cycle_type_bit_0_n <= type_d[0];
      if (ts_d == T_ONE) begin
        ad_out <= start_data ? eu_req_addr[DATA_W-1:0] : fetch_addr_q[DATA_W-1:0];
        addr_hi <= start_data ? eu_req_addr[ADDR_W-1:DATA_W] : fetch_addr_q[ADDR_W-1:DATA_W];
        ad_oe_n <= 1'b0;
      end else if ((ts_d != T_IDLE) && (kind_d == K_WRITE)) begin
        ad_out <= cyc_wdata_q;
        ad_oe_n <= 1'b0;
      end else begin
        ad_oe_n <= 1'b1;
      end
    end
  end

  always_comb begin
    qs_d = QS_NONE;
    if (eu_jump) begin
      qs_d = QS_FLUSH;
    end else if (eu_take && eu_byte_valid) begin
      qs_d = eu_first ? QS_FIRST : QS_NEXT;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      queue_state_bit_low <= 1'b0;
      queue_state_bit_high <= 1'b0;
    end else begin
      queue_state_bit_low <= qs_d[0];
      queue_state_bit_high <= qs_d[1];
    end
  end

endmodule

// >>> pfq_pkg.sv
// Purpose: Shared constants and types for the prefetch queue and bus control block
// Assumes: One processor clock; multiplexed 16-bit address/data bus
// Notes: Status codes on the bus are active low; all-ones is passive
package pfq_pkg;

  // Clock and sizes
  localparam int CLK_PERIOD_NS = 100;
  localparam int ADDR_W = 20;
  localparam int DATA_W = 16;
  localparam int BYTE_W = 8;
  localparam int QUEUE_DEPTH = 8;
  localparam int QUEUE_CAP_BYTES = 6;
  localparam int QUEUE_FULL_BYTES = 5;
  localparam int WORD_BYTES = 2;
  localparam int QUEUE_ROOM_LIMIT = QUEUE_CAP_BYTES - WORD_BYTES;
  localparam int CNT_W = $clog2(QUEUE_DEPTH + 1);

  // Idle clocks left on the bus after an abandoned fetch
  localparam logic [1:0] ABORT_IDLE = 2'h2;

  // Active-low bus cycle type codes
  localparam logic [2:0] BUS_FETCH = 3'h4;
  localparam logic [2:0] BUS_READ = 3'h5;
  localparam logic [2:0] BUS_WRITE = 3'h6;
  localparam logic [2:0] BUS_PASSIVE = 3'h7;

  // Queue status codes {high, low}
  localparam logic [1:0] QS_NONE = 2'h0;
  localparam logic [1:0] QS_FIRST = 2'h1;
  localparam logic [1:0] QS_FLUSH = 2'h2;
  localparam logic [1:0] QS_NEXT = 2'h3;

  // Staging buffer fill levels and address step
  localparam logic [1:0] STAGE_EMPTY = 2'h0;
  localparam logic [1:0] STAGE_ONE = 2'h1;
  localparam logic [1:0] STAGE_TWO = 2'h2;
  localparam logic [ADDR_W-1:0] ADDR_STEP = 20'h00002;
  localparam logic [ADDR_W-1:0] ADDR_EVEN = 20'hFFFFE;

  typedef enum logic [2:0] {T_IDLE, T_ONE, T_TWO, T_THREE, T_WAIT, T_FOUR} tstate_e;
  typedef enum logic [1:0] {K_FETCH, K_READ, K_WRITE} cycle_kind_e;

endpackage

// >>> pfq_byte_fifo.sv
// Purpose: Synchronous FIFO holding the prefetched instruction bytes
// Assumes: Single clock; clear empties it at once
// Notes: Count output lets the fetcher judge room ahead of time
`timescale 1ns/1ns
module pfq_byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic clear,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  // Fill level
  output logic [$clog2(DEPTH+1)-1:0] count
);

  localparam int PW = $clog2(DEPTH);
  localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);
  localparam logic [$clog2(DEPTH+1)-1:0] CNT_FULL = ($clog2(DEPTH+1))'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_q;
  logic [PW-1:0] rd_q;
  logic [$clog2(DEPTH+1)-1:0] cnt_q;
  logic push;
  logic pop;

  // Handshake terms
  assign in_ready = (cnt_q != CNT_FULL);
  assign out_valid = (cnt_q != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_q];
  assign count = cnt_q;

  // Storage
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end

  // Pointers and level
  always_ff @(posedge clk_sys) begin
    if (!rstn || clear) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == PTR_LAST) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == PTR_LAST) ? '0 : rd_q + 1'b1;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end

endmodule

// >>> pfq_tstate_seq.sv
// Purpose: Steps one bus cycle through its clock states
// Assumes: ready_sync already passed a two-stage synchroniser
// Notes: Abort is honoured only in the first state
`timescale 1ns/1ns
module pfq_tstate_seq
  import pfq_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Control
  input wire logic start,
  input wire logic abort,
  input wire logic ready_sync,
  // State
  output tstate_e state_q,
  output tstate_e state_d
);

  // Next state of the bus cycle
  always_comb begin
    state_d = state_q;
    case (state_q)
      T_IDLE: begin
        if (start) begin
          state_d = T_ONE;
        end
      end
      T_ONE: begin
        state_d = abort ? T_IDLE : T_TWO;
      end
      T_TWO: begin
        state_d = T_THREE;
      end
      T_THREE, T_WAIT: begin
        state_d = ready_sync ? T_FOUR : T_WAIT;
      end
      T_FOUR: begin
        state_d = start ? T_ONE : T_IDLE;
      end
      default: begin
        state_d = T_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      state_q <= T_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

endmodule

// >>> pfq_bus_checker_properties.sv
// Purpose: Checks bus framing, data requests and queue status
// Assumes: Sees only the top module ports
// Notes: Bound into every instance of the top module
`timescale 1ns/1ns
module pfq_bus_checker
  import pfq_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Execution unit
  input wire logic eu_take,
  input wire logic eu_first,
  input wire logic eu_byte_valid,
  input wire logic eu_jump,
  input wire logic eu_req,
  input wire logic eu_req_write,
  input wire logic [ADDR_W-1:0] eu_req_addr,
  input wire logic eu_done,
  // Bus pins
  input wire logic [DATA_W-1:0] ad_out,
  input wire logic ad_oe_n,
  input wire logic ale,
  input wire logic bus_cycle_type_bit_2_n,
  input wire logic bus_cycle_type_bit_1_n,
  input wire logic bus_cycle_type_bit_0_n,
  // Queue status
  input wire logic queue_state_bit_low,
  input wire logic queue_state_bit_high
);
  logic [2:0] st;
  logic [1:0] qs;
  logic pop;
  logic dat;
  // Gathered codes and events
  assign st = {bus_cycle_type_bit_2_n, bus_cycle_type_bit_1_n, bus_cycle_type_bit_0_n};
  assign qs = {queue_state_bit_high, queue_state_bit_low};
  assign pop = eu_take && eu_byte_valid && !eu_jump;
  assign dat = ale && st != BUS_FETCH;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  a_ale_single: assert property (ale |=> !ale)
    else $error("ale longer than one clock");
  a_first_drive: assert property (ale |-> st != BUS_PASSIVE && !ad_oe_n)
    else $error("first state lacks status or drive");
  a_three_active: assert property (ale ##1 st != BUS_PASSIVE |-> (st != BUS_PASSIVE)[*2])
    else $error("cycle shorter than three active states");
  a_abort_idle: assert property (ale && st == BUS_FETCH && eu_req && !eu_done |=>
    st == BUS_PASSIVE ##1 st == BUS_PASSIVE ##1 (ale && st != BUS_FETCH))
    else $error("abandoned fetch not followed by two idle clocks and the data cycle");
  a_cycle_ends: assert property (ale |-> ##[3:40] st == BUS_PASSIVE)
    else $error("bus cycle never ends");
  a_data_kind: assert property (dat |-> eu_req && st == (eu_req_write ? BUS_WRITE : BUS_READ))
    else $error("data cycle without matching request");
  a_data_addr: assert property (dat |-> ad_out == eu_req_addr[DATA_W-1:0])
    else $error("data cycle address wrong");
  a_req_served: assert property ($rose(eu_req) |-> ##[1:40] dat)
    else $error("request not served in time");
  a_qs_first: assert property (pop && eu_first |=> qs == QS_FIRST)
    else $error("first byte status wrong");
  a_qs_next: assert property (pop && !eu_first |=> qs == QS_NEXT)
    else $error("next byte status wrong");
  a_qs_flush: assert property (eu_jump |=> qs == QS_FLUSH)
    else $error("flush status wrong");
  cover property (ale && st == BUS_FETCH);
  cover property (ale && st == BUS_READ);
  cover property (ale && st == BUS_WRITE);
  cover property (ale ##1 st == BUS_PASSIVE);
endmodule
bind prefetch_queue_bus_control pfq_bus_checker u_chk (.clk_sys(clk_sys), .rstn(rstn),
  .eu_take(eu_take), .eu_first(eu_first), .eu_byte_valid(eu_byte_valid), .eu_jump(eu_jump),
  .eu_req(eu_req), .eu_req_write(eu_req_write), .eu_req_addr(eu_req_addr), .eu_done(eu_done),
  .ad_out(ad_out), .ad_oe_n(ad_oe_n), .ale(ale), .bus_cycle_type_bit_2_n(bus_cycle_type_bit_2_n),
  .bus_cycle_type_bit_1_n(bus_cycle_type_bit_1_n), .bus_cycle_type_bit_0_n(bus_cycle_type_bit_0_n),
  .queue_state_bit_low(queue_state_bit_low), .queue_state_bit_high(queue_state_bit_high));

// >>> pfq_mem_model.sv
// Purpose: Memory on the multiplexed bus, word value from its address
// Assumes: Address latched while ale is high
// Notes: Undriven data lines toggle so stale data never matches
`timescale 1ns/1ns
module pfq_mem_model
  import pfq_pkg::*;
(
  // Bus from the block
  input wire logic clk_sys,
  input wire logic [DATA_W-1:0] ad_out,
  input wire logic ad_oe_n,
  input wire logic [ADDR_W-DATA_W-1:0] addr_hi,
  input wire logic ale,
  input wire logic [2:0] st,
  // Bus to the block
  output logic [DATA_W-1:0] ad_in,
  output logic ready,
  // Test control and capture
  input wire logic [3:0] n_wait,
  output logic [ADDR_W-1:0] wr_addr,
  output logic [DATA_W-1:0] wr_data
);
  logic [ADDR_W-1:0] addr = 20'h00000;
  logic [3:0] wcnt = 4'h0;
  assign ready = ale ? (n_wait == 4'h0) : (wcnt == 4'h0);
  always @(posedge clk_sys) begin
    if (ale) begin
      addr <= {addr_hi, ad_out};
      wcnt <= n_wait - {3'h0, n_wait != 4'h0};
      ad_in <= {ad_out[7:0] + 8'h01, ad_out[7:0]};
    end else begin
      wcnt <= wcnt - {3'h0, wcnt != 4'h0};
      ad_in <= (st == BUS_FETCH || st == BUS_READ) ? ad_in : ~ad_in;
    end
    if (st == BUS_WRITE && !ale && !ad_oe_n) begin
      wr_addr <= addr;
      wr_data <= ad_out;
    end
  end
endmodule

// >>> prefetch_queue_bus_control_tb_top.sv
// Purpose: Scenario bench for the prefetch queue and bus control
// Assumes: Memory model answers every bus cycle
// Notes: Inputs change 10 ns after the rising edge
`timescale 1ns/1ns
module prefetch_queue_bus_control_tb_top;
  import pfq_pkg::*;
  logic clk_sys, rstn, eu_take, eu_first, eu_jump, eu_req, eu_req_write;
  logic [ADDR_W-1:0] eu_jump_addr, eu_req_addr, wr_addr, last_addr;
  logic [DATA_W-1:0] eu_req_wdata, eu_rdata, ad_out, ad_in, wr_data;
  logic [BYTE_W-1:0] eu_byte;
  logic [3:0] addr_hi, n_wait;
  logic [2:0] st;
  logic eu_byte_valid, eu_done, ad_oe_n, ale, ready, ql, qh;
  int n_errors, cmp_count, n_fetch, run, last_run, cyc, t_f, t_d, i, k;
  prefetch_queue_bus_control uut (.clk_sys(clk_sys), .rstn(rstn), .eu_take(eu_take),
    .eu_first(eu_first), .eu_byte(eu_byte), .eu_byte_valid(eu_byte_valid), .eu_jump(eu_jump),
    .eu_jump_addr(eu_jump_addr), .eu_req(eu_req), .eu_req_write(eu_req_write),
    .eu_req_addr(eu_req_addr), .eu_req_wdata(eu_req_wdata), .eu_done(eu_done),
    .eu_rdata(eu_rdata), .ad_out(ad_out), .ad_in(ad_in), .ad_oe_n(ad_oe_n), .addr_hi(addr_hi),
    .ale(ale), .ready(ready), .bus_cycle_type_bit_2_n(st[2]), .bus_cycle_type_bit_1_n(st[1]),
    .bus_cycle_type_bit_0_n(st[0]), .queue_state_bit_low(ql), .queue_state_bit_high(qh));
  pfq_mem_model mem (.clk_sys(clk_sys), .ad_out(ad_out), .ad_oe_n(ad_oe_n), .addr_hi(addr_hi),
    .ale(ale), .st(st), .ad_in(ad_in), .ready(ready), .n_wait(n_wait), .wr_addr(wr_addr),
    .wr_data(wr_data));
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  // Bus monitor: fetch count, fetch-to-data start gap, active run length
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (ale && st == BUS_FETCH) begin
      n_fetch <= n_fetch + 1;
      last_addr <= {addr_hi, ad_out};
      t_f <= cyc;
    end
    if (ale && st != BUS_FETCH) t_d <= cyc - t_f;
    run <= (st != BUS_PASSIVE) ? run + 1 : 0;
    if (st == BUS_PASSIVE && run != 0) last_run <= run;
  end
  task automatic tally_and_finish();
    $display("errors=%0d compares=%0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #10;
  endtask
  task automatic bail(input int j);
    if (j >= 60) begin
      n_errors++;
      tally_and_finish();
    end
  endtask
  // Take one queued byte, stalling while the queue is empty
  task automatic take(input logic [7:0] exp, input logic f);
    for (i = 0; i < 60 && eu_byte_valid !== 1'b1; i++) step(1);
    bail(i);
    chk(eu_byte, exp);
    eu_take = 1'b1;
    eu_first = f;
    step(1);
    eu_take = 1'b0;
    step(1);
  endtask
  // Data cycle request held until done
  task automatic bus_req(input logic w, input logic [19:0] a, input logic [15:0] d);
    eu_req_write = w;
    eu_req_addr = a;
    eu_req_wdata = d;
    eu_req = 1'b1;
    for (i = 0; i < 60; i++) begin
      step(1);
      if (eu_done === 1'b1) break;
    end
    bail(i);
    step(1);
    eu_req = 1'b0;
    step(1);
  endtask
  task automatic s_fill();
    step(40);
    chk(n_fetch, 3);
    chk(last_addr, 20'h00004);
    take(8'h00, 1'b1);
    step(15);
    chk(n_fetch, 3);
    take(8'h01, 1'b0);
    step(15);
    chk(n_fetch, 4);
    chk(last_addr, 20'h00006);
  endtask
  task automatic s_stream();
    for (k = 2; k < 20; k++) take(k[7:0], k[0]);
  endtask
  task automatic s_abort_read();
    for (k = 0; k < 60 && !(ale === 1'b1 && st === BUS_FETCH); k++) step(1);
    bail(k);
    bus_req(1'b0, 20'h00234, 16'h0000);
    chk(eu_rdata, 16'h3534);
    chk(t_d, 3);
    chk(last_run, 3);
  endtask
  task automatic s_write_wait();
    n_wait = 4'h2;
    bus_req(1'b1, 20'h00310, 16'hBEEF);
    chk(wr_addr, 20'h00310);
    chk(wr_data, 16'hBEEF);
    chk(t_d, 4);
    chk(last_run, 5);
    n_wait = 4'h0;
  endtask
  task automatic s_jump();
    eu_jump_addr = 20'h00141;
    eu_jump = 1'b1;
    step(1);
    eu_jump = 1'b0;
    for (k = 0; k < 60 && last_addr !== 20'h00140; k++) step(1);
    bail(k);
    chk(last_addr, 20'h00140);
    take(8'h40, 1'b1);
    take(8'h41, 1'b0);
  endtask
  initial begin
    {rstn, eu_take, eu_first, eu_jump, eu_req, eu_req_write} = 6'h00;
    eu_jump_addr = 20'h00000;
    eu_req_addr = 20'h00000;
    eu_req_wdata = 16'h0000;
    n_wait = 4'h0;
    step(8);
    rstn = 1'b1;
    s_fill();
    s_stream();
    take(8'h14, 1'b1);
    take(8'h15, 1'b0);
    s_abort_read();
    s_write_wait();
    s_jump();
    tally_and_finish();
  end
endmodule
